// File: core/tss_i2c_slave.sv
`include "tss_defines.svh"

// How it works
// - temperature register holds latest 12-bit result
// - temperature read sends upper byte first
// - low four bits of temperature word zero
// - temperature reads zero after any reset
// - resolution 9 to 12 bits masks low bits
// - two's complement sixteenths, saturating at 7FF
// - slave only, open drain, MSB first
// - fast and high-speed clock rates supported
// - SDA moves only while SCL low
// - address byte then ack on ninth clock
// - address 1001 plus three pin levels
// - pins latched after reset, start, request
// - first written byte loads the pointer
// - reads reuse the last written pointer
// - words move upper byte then lower byte
// - receiver acks address, pointer, data bytes
// - transmitter sends two bytes, master may nack
// - alert response acked, own address returned
// - alert byte last bit shows high limit
// - arbitration winner clears alert, loser keeps
// - general call latch or latch and reset
// - high-speed code unacked, held until stop
// - pointer low bits select four registers
// - thermostat mode bit selects interrupt behaviour
module tss_i2c_slave
  import tss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin_0,
  input wire logic addr_select_pin_1,
  input wire logic addr_select_pin_2,
  input wire tss_conv_t conv,
  input wire logic alert_active,
  input wire logic temp_above_high,
  output tss_regs_t regs,
  output logic [11:0] temp_value,
  output logic thermostat_mode_bit,
  output logic temp_read,
  output logic alert_clear,
  output logic one_shot,
  output logic hs_mode
);

  // ****************************************
  // input conditioning
  // ****************************************
  logic [1:0] bus_f;
  logic [2:0] pins_f;
  logic scl_f, sda_f;

  tss_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
    .clk(clk),
    .rst(rst),
    .din({scl_in, sda_in}),
    .dout(bus_f)
  );

  tss_sync #(.WIDTH(3), .INIT(3'h0)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .din({addr_select_pin_2, addr_select_pin_1, addr_select_pin_0}),
    .dout(pins_f)
  );

  assign scl_f = bus_f[1];
  assign sda_f = bus_f[0];

  // ****************************************
  // state
  // ****************************************
  tss_state_t state_reg, state_next;
  logic scl_d_reg, scl_d_next;
  logic sda_d_reg, sda_d_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic sda_oe_reg, sda_oe_next;
  logic [2:0] byte_idx_reg, byte_idx_next;
  logic read_reg, read_next;
  logic gc_reg, gc_next;
  logic alert_reg, alert_next;
  logic half_reg, half_next;
  logic nack_reg, nack_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] msb_reg, msb_next;
  tss_regs_t regs_reg, regs_next;
  logic [2:0] addr_reg, addr_next;
  logic relatch_reg, relatch_next;
  logic hs_reg, hs_next;
  logic temp_read_reg, temp_read_next;
  logic alert_clear_reg, alert_clear_next;
  logic one_shot_reg, one_shot_next;
  logic soft_rst_reg, soft_rst_next;
  logic [11:0] temp12;

  logic scl_rise, scl_fall, start, stop, byte_done, gc_reset_cmd;

  assign scl_rise = scl_f & ~scl_d_reg;
  assign scl_fall = ~scl_f & scl_d_reg;
  assign start = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  assign stop = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  assign byte_done = (state_reg == ST_RX) & scl_fall & (bit_cnt_reg == 4'h8);
  assign gc_reset_cmd = byte_done & gc_reg & (byte_idx_reg == 3'h1) & (shift_reg == `TSS_GC_RESET);

  // ****************************************
  // register readback
  // ****************************************
  function automatic logic [15:0] read_word(input logic [1:0] p, input tss_regs_t r, input logic [11:0] t);
    logic [15:0] w;
    case (p)
      `TSS_PTR_TEMP: w = {t, 4'h0};
      `TSS_PTR_CFG: w = {1'h0, r.cfg[6:0], 8'h00};
      `TSS_PTR_TLOW: w = r.tlow;
      `TSS_PTR_THIGH: w = r.thigh;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // ****************************************
  // protocol engine
  // ****************************************
  always_comb begin
    logic ack;
    logic [7:0] b;
    logic [7:0] first;
    logic [15:0] word;
    ack = 1'h0;
    b = shift_reg;
    first = 8'h00;
    word = read_word(ptr_reg[1:0], regs_reg, temp12);
    state_next = state_reg;
    scl_d_next = scl_f;
    sda_d_next = sda_f;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    sda_oe_next = sda_oe_reg;
    byte_idx_next = byte_idx_reg;
    read_next = read_reg;
    gc_next = gc_reg;
    alert_next = alert_reg;
    half_next = half_reg;
    nack_next = nack_reg;
    ptr_next = ptr_reg;
    msb_next = msb_reg;
    regs_next = regs_reg;
    addr_next = relatch_reg ? pins_f : addr_reg;
    relatch_next = 1'h0;
    hs_next = hs_reg;
    temp_read_next = 1'h0;
    alert_clear_next = 1'h0;
    one_shot_next = 1'h0;
    soft_rst_next = 1'h0;
    if (start) begin
      state_next = ST_RX;
      bit_cnt_next = 4'h0;
      byte_idx_next = 3'h0;
      sda_oe_next = 1'h0;
      half_next = 1'h0;
      relatch_next = 1'h1;
    end else if (stop) begin
      state_next = ST_IDLE;
      sda_oe_next = 1'h0;
      hs_next = 1'h0;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (scl_rise && bit_cnt_reg < 4'h8) begin
            shift_next = {shift_reg[6:0], sda_f};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          if (byte_done) begin
            case (byte_idx_reg)
              3'h0: begin
                if (b[7:1] == {`TSS_ADDR_HI, addr_reg}) begin
                  ack = 1'h1;
                  read_next = b[0];
                  gc_next = 1'h0;
                  alert_next = 1'h0;
                end else if (b[7:1] == `TSS_GC_ADDR && !b[0]) begin
                  ack = 1'h1;
                  read_next = 1'h0;
                  gc_next = 1'h1;
                  alert_next = 1'h0;
                end else if (b == `TSS_ALERT_RESP && regs_reg.cfg[`TSS_CFG_TM] && alert_active) begin
                  ack = 1'h1;
                  read_next = 1'h1;
                  gc_next = 1'h0;
                  alert_next = 1'h1;
                end else if (b[7:3] == `TSS_HS_CODE) begin
                  hs_next = 1'h1;
                end
              end
              3'h1: begin
                if (gc_reg) begin
                  if (b == `TSS_GC_LATCH || b == `TSS_GC_RESET) begin
                    ack = 1'h1;
                    relatch_next = 1'h1;
                  end
                  if (b == `TSS_GC_RESET) begin
                    regs_next.cfg = `TSS_CFG_RESET;
                    regs_next.tlow = `TSS_TLOW_RESET;
                    regs_next.thigh = `TSS_THIGH_RESET;
                    ptr_next = `TSS_PTR_RESET;
                    soft_rst_next = 1'h1;
                  end
                end else begin
                  ack = 1'h1;
                  ptr_next = {6'h00, b[1:0]};
                end
              end
              3'h2: begin
                ack = !gc_reg;
                msb_next = b;
                if (!gc_reg && ptr_reg[1:0] == `TSS_PTR_CFG) begin
                  regs_next.cfg = b;
                  one_shot_next = b[`TSS_CFG_OS];
                end
              end
              3'h3: begin
                ack = !gc_reg;
                if (!gc_reg && ptr_reg[1:0] == `TSS_PTR_TLOW) begin
                  regs_next.tlow = {msb_reg, b[7:4], 4'h0};
                end
                if (!gc_reg && ptr_reg[1:0] == `TSS_PTR_THIGH) begin
                  regs_next.thigh = {msb_reg, b[7:4], 4'h0};
                end
              end
              default: ack = !gc_reg;
            endcase
            byte_idx_next = (byte_idx_reg == 3'h4) ? byte_idx_reg : byte_idx_reg + 3'h1;
            sda_oe_next = ack;
            state_next = ack ? ST_RACK : ST_SKIP;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            sda_oe_next = 1'h0;
            state_next = ST_RX;
            if (read_reg) begin
              if (alert_reg) begin
                first = {`TSS_ADDR_HI, addr_reg, temp_above_high};
              end else begin
                first = word[15:8];
                temp_read_next = (ptr_reg[1:0] == `TSS_PTR_TEMP);
              end
              sda_oe_next = ~first[7];
              tx_next = {first[6:0], 1'h0};
              bit_cnt_next = 4'h1;
              state_next = ST_TX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise && alert_reg && !sda_oe_reg && !sda_f) begin
            state_next = ST_SKIP;
          end else if (scl_fall) begin
            if (bit_cnt_reg < 4'h8) begin
              sda_oe_next = ~tx_reg[7];
              tx_next = {tx_reg[6:0], 1'h0};
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end else begin
              sda_oe_next = 1'h0;
              state_next = ST_TACK;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            nack_next = sda_f;
          end
          if (scl_fall) begin
            state_next = ST_SKIP;
            if (alert_reg) begin
              alert_clear_next = 1'h1;
            end else if (!nack_reg && !half_reg) begin
              first = word[7:0];
              half_next = 1'h1;
              sda_oe_next = ~first[7];
              tx_next = {first[6:0], 1'h0};
              bit_cnt_next = 4'h1;
              state_next = ST_TX;
            end
          end
        end
        ST_SKIP: sda_oe_next = 1'h0;
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      sda_oe_reg <= 1'h0;
      byte_idx_reg <= 3'h0;
      read_reg <= 1'h0;
      gc_reg <= 1'h0;
      alert_reg <= 1'h0;
      half_reg <= 1'h0;
      nack_reg <= 1'h0;
      ptr_reg <= `TSS_PTR_RESET;
      msb_reg <= 8'h00;
      regs_reg <= {`TSS_CFG_RESET, `TSS_TLOW_RESET, `TSS_THIGH_RESET};
      addr_reg <= 3'h0;
      relatch_reg <= 1'h1;
      hs_reg <= 1'h0;
      temp_read_reg <= 1'h0;
      alert_clear_reg <= 1'h0;
      one_shot_reg <= 1'h0;
      soft_rst_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      sda_oe_reg <= sda_oe_next;
      byte_idx_reg <= byte_idx_next;
      read_reg <= read_next;
      gc_reg <= gc_next;
      alert_reg <= alert_next;
      half_reg <= half_next;
      nack_reg <= nack_next;
      ptr_reg <= ptr_next;
      msb_reg <= msb_next;
      regs_reg <= regs_next;
      addr_reg <= addr_next;
      relatch_reg <= relatch_next;
      hs_reg <= hs_next;
      temp_read_reg <= temp_read_next;
      alert_clear_reg <= alert_clear_next;
      one_shot_reg <= one_shot_next;
      soft_rst_reg <= soft_rst_next;
    end
  end

  // ****************************************
  // temperature register
  // ****************************************
  tss_temp_reg u_temp (
    .clk(clk),
    .rst(rst),
    .clear(soft_rst_reg),
    .conv(conv),
    .res(regs_reg.cfg[`TSS_CFG_RES_HI:`TSS_CFG_RES_LO]),
    .temp(temp12)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign sda_out = 1'h0;
  assign sda_oe = sda_oe_reg;
  assign regs = regs_reg;
  assign temp_value = temp12;
  assign thermostat_mode_bit = regs_reg.cfg[`TSS_CFG_TM];
  assign temp_read = temp_read_reg;
  assign alert_clear = alert_clear_reg;
  assign one_shot = one_shot_reg;
  assign hs_mode = hs_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_temp_low_zero: assert property (state_reg == ST_TX && half_reg && ptr_reg[1:0] == `TSS_PTR_TEMP
    && bit_cnt_reg > 4'h4 |-> sda_oe_reg)
    else $error("temperature word low nibble not zero");
  a_ptr_upper_zero: assert property (ptr_reg[7:2] == 6'h00)
    else $error("pointer upper bits not zero");
  a_sda_moves_low: assert property ($changed(sda_oe_reg) |-> !$past(scl_f) || $past(start || stop))
    else $error("sda drive changed while scl high");
  a_hs_until_stop: assert property (stop |=> !hs_reg)
    else $error("high-speed mode kept after stop");
  a_hs_no_ack: assert property ($rose(hs_reg) |-> state_reg == ST_SKIP && !sda_oe_reg)
    else $error("high-speed code acknowledged");
  a_addr_ack: assert property (byte_done && byte_idx_reg == 3'h0 && shift_reg[7:1] == {4'h9, addr_reg}
    |=> sda_oe_reg && state_reg == ST_RACK)
    else $error("own address not acknowledged");
  a_ptr_load: assert property (byte_done && byte_idx_reg == 3'h1 && !gc_reg
    |=> ptr_reg[1:0] == $past(shift_reg[1:0]) ##1 state_reg == ST_RACK)
    else $error("pointer byte not loaded");
  a_arb_release: assert property (state_reg == ST_TX && alert_reg && scl_rise && !sda_oe_reg && !sda_f
    |=> state_reg == ST_SKIP && !sda_oe_reg)
    else $error("arbitration loss did not release sda");
  a_gc_reset: assert property (gc_reset_cmd |=> regs_reg.cfg == 8'h00 && ptr_reg == 8'h00 ##1 temp12 == 12'h000)
    else $error("general call reset did not restore registers");

endmodule

// File: include/tss_defines.svh
`ifndef TSS_DEFINES_SVH
`define TSS_DEFINES_SVH

// ****************************************
// bus addressing and command codes
// ****************************************
`define TSS_ADDR_HI 4'h9
`define TSS_GC_ADDR 7'h00
`define TSS_GC_LATCH 8'h04
`define TSS_GC_RESET 8'h06
`define TSS_ALERT_RESP 8'h19
`define TSS_HS_CODE 5'h01

// ****************************************
// pointer codes
// ****************************************
`define TSS_PTR_TEMP 2'h0
`define TSS_PTR_CFG 2'h1
`define TSS_PTR_TLOW 2'h2
`define TSS_PTR_THIGH 2'h3
`define TSS_PTR_RESET 8'h00

// ****************************************
// configuration fields and reset values
// ****************************************
`define TSS_CFG_OS 7
`define TSS_CFG_RES_HI 6
`define TSS_CFG_RES_LO 5
`define TSS_CFG_TM 1
`define TSS_CFG_RESET 8'h00
`define TSS_TLOW_RESET 16'h0000
`define TSS_THIGH_RESET 16'h0000
`define TSS_TEMP_RESET 12'h000
`define TSS_TEMP_MAX 16'sh07FF
`define TSS_TEMP_MIN 16'shF800

// ****************************************
// timing
// ****************************************
`define TSS_CLK_KHZ 25000
`define TSS_FS_SCL_KHZ 400
`define TSS_HS_SCL_KHZ 2380
`define TSS_FS_PERIOD_CYC ((`TSS_CLK_KHZ + `TSS_FS_SCL_KHZ - 1) / `TSS_FS_SCL_KHZ)
`define TSS_HS_PERIOD_CYC ((`TSS_CLK_KHZ + `TSS_HS_SCL_KHZ - 1) / `TSS_HS_SCL_KHZ)

`endif

// File: include/tss_pkg.sv
package tss_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_RACK = 6'h04,
    ST_TX = 6'h08,
    ST_TACK = 6'h10,
    ST_SKIP = 6'h20
  } tss_state_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [15:0] tlow;
    logic [15:0] thigh;
  } tss_regs_t;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } tss_conv_t;

endpackage

// File: core/tss_sync.sv
`include "tss_defines.svh"

module tss_sync
  import tss_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ****************************************
  // three stage synchroniser with agreement
  // ****************************************
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic [WIDTH-1:0] s1_next, s2_next, s3_next, filt_next;

  always_comb begin
    s1_next = din;
    s2_next = s1_reg;
    s3_next = s2_reg;
    filt_next = filt_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      filt_reg <= INIT;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      filt_reg <= filt_next;
    end
  end

  assign dout = filt_reg;

endmodule

// File: core/tss_temp_reg.sv
`include "tss_defines.svh"

module tss_temp_reg
  import tss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire tss_conv_t conv,
  input wire logic [1:0] res,
  output logic [11:0] temp
);

  // ****************************************
  // saturation and resolution
  // ****************************************
  function automatic logic [11:0] shape(input logic [15:0] code, input logic [1:0] r);
    logic signed [15:0] c;
    logic [11:0] v;
    c = signed'(code);
    if (c >= `TSS_TEMP_MAX) begin
      v = 12'h7FF;
    end else if (c <= `TSS_TEMP_MIN) begin
      v = 12'h800;
    end else begin
      v = code[11:0];
    end
    return v & ~(12'h7 >> r);
  endfunction

  logic [11:0] temp_reg, temp_next;

  always_comb begin
    temp_next = temp_reg;
    if (clear) begin
      temp_next = `TSS_TEMP_RESET;
    end else if (conv.valid) begin
      temp_next = shape(conv.code, res);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      temp_reg <= `TSS_TEMP_RESET;
    end else begin
      temp_reg <= temp_next;
    end
  end

  assign temp = temp_reg;

  a_res_nine_mask: assert property (@(posedge clk) disable iff (rst)
    (conv.valid && !clear && res == 2'h0) |=> temp_reg[2:0] == 3'h0)
    else $error("low bits not cleared at 9-bit resolution");
  a_reset_reads_zero: assert property (@(posedge clk)
    rst |=> temp_reg == 12'h000)
    else $error("temperature not zero after reset");

endmodule

// File: verif/tss_master_model.sv
module tss_master_model
  import tss_pkg::*;
(
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // bus master, 8 clk per scl period
  // ****************************************
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // start or repeated start, scl left low
  task automatic start();
    wt(2);
    sda_drv = 1'h1;
    wt(4);
    scl = 1'h1;
    wt(4);
    sda_drv = 1'h0;
    wt(4);
    scl = 1'h0;
  endtask

  task automatic stop();
    wt(2);
    sda_drv = 1'h0;
    wt(4);
    scl = 1'h1;
    wt(4);
    sda_drv = 1'h1;
    wt(8);
  endtask

  // byte plus ack bit, a one releases the line to the pull-up
  // scl low 5 clk so the slave drive settles before scl rises
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    logic [8:0] sh;
    logic r;
    sh = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      wt(2);
      sda_drv = sh[i];
      wt(3);
      scl = 1'h1;
      wt(3);
      r = sda_wire;
      scl = 1'h0;
      if (i > 0) rx[i-1] = r;
      else ack_out = r;
    end
  endtask
endmodule

// File: verif/temp_sensor_serial_slave_tb_top.sv
module temp_sensor_serial_slave_tb_top
  import tss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // signals and instances
  // ****************************************
  localparam logic [6:0] DEV = 7'h4D;
  logic clk, rst, scl, sda_drv, sda_wire, sda_out, sda_oe;
  logic pin0, pin1, pin2, alert_active, temp_above_high;
  logic tm, temp_read, alert_clear, one_shot, hs_mode;
  tss_conv_t conv;
  tss_regs_t regs;
  logic [11:0] temp_value;
  int errors, check_count, clr_seen, tr_seen, os_seen;

  assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'h1);

  tss_i2c_slave uut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_pin_0(pin0), .addr_select_pin_1(pin1), .addr_select_pin_2(pin2),
    .conv(conv), .alert_active(alert_active), .temp_above_high(temp_above_high), .regs(regs),
    .temp_value(temp_value), .thermostat_mode_bit(tm), .temp_read(temp_read),
    .alert_clear(alert_clear), .one_shot(one_shot), .hs_mode(hs_mode));

  tss_master_model m (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  always @(negedge clk) begin
    if (alert_clear === 1'h1) clr_seen++;
    if (temp_read === 1'h1) tr_seen++;
    if (one_shot === 1'h1) os_seen++;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic ack_exp);
    logic [7:0] rx;
    logic a;
    m.xfer(b, 1'h1, rx, a);
    chk(16'(a), 16'(ack_exp));
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
    m.start();
    send({DEV, 1'h0}, 1'h0);
    send(p, 1'h0);
    for (int i = 0; i < n; i++) send(i == 0 ? d[15:8] : d[7:0], 1'h0);
    m.stop();
  endtask

  task automatic rd(output logic [15:0] w);
    logic a;
    m.start();
    send({DEV, 1'h1}, 1'h0);
    m.xfer(8'hFF, 1'h0, w[15:8], a);
    m.xfer(8'hFF, 1'h1, w[7:0], a);
    m.stop();
  endtask

  task automatic cv(input logic [15:0] c);
    @(negedge clk);
    conv = '{valid: 1'h1, code: c};
    @(negedge clk);
    conv.valid = 1'h0;
    @(negedge clk);
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    logic [15:0] w;
    logic [7:0] rx;
    logic a;
    logic [15:0] codes [3];
    logic [15:0] words [3];
    codes = '{16'h0190, 16'hFE70, 16'h0900};
    words = '{16'h1900, 16'hE700, 16'h7FF0};
    errors = 0;
    check_count = 0;
    clr_seen = 0;
    tr_seen = 0;
    os_seen = 0;
    rst = 1'h1;
    pin2 = 1'h1;
    pin1 = 1'h0;
    pin0 = 1'h1;
    conv = '0;
    alert_active = 1'h0;
    temp_above_high = 1'h1;
    repeat (5) @(negedge clk);
    rst = 1'h0;
    repeat (8) @(negedge clk);
    chk(16'(temp_value), 16'h0000);
    chk(regs.thigh, 16'h0000);
    wr(8'h01, 16'h6200, 1);
    chk(16'(regs.cfg), 16'h0062);
    chk(16'(tm), 16'h0001);
    wr(8'h00, 16'h0000, 0);
    for (int i = 0; i < 3; i++) begin
      cv(codes[i]);
      rd(w);
      chk(w, words[i]);
    end
    wr(8'h01, 16'h8200, 1);
    chk(16'(os_seen), 16'h0001);
    cv(16'h0197);
    chk(16'(temp_value), 16'h0190);
    rd(w);
    chk(w, 16'h0200);
    wr(8'h03, 16'h1235, 2);
    chk(regs.thigh, 16'h1230);
    rd(w);
    chk(w, 16'h1230);
    m.start();
    send(8'h90, 1'h1);
    m.stop();
    m.start();
    send(8'h19, 1'h1);
    m.stop();
    alert_active = 1'h1;
    m.start();
    send(8'h19, 1'h0);
    m.xfer(8'hFF, 1'h1, rx, a);
    chk(16'(rx), 16'h009B);
    m.stop();
    chk(16'(clr_seen), 16'h0001);
    m.start();
    send(8'h19, 1'h0);
    m.xfer(8'h91, 1'h1, rx, a);
    chk(16'(rx), 16'h0091);
    m.stop();
    chk(16'(clr_seen), 16'h0001);
    m.start();
    send(8'h08, 1'h1);
    chk(16'(hs_mode), 16'h0001);
    m.stop();
    chk(16'(hs_mode), 16'h0000);
    pin1 = 1'h1;
    m.start();
    send({7'h4F, 1'h0}, 1'h0);
    m.stop();
    pin1 = 1'h0;
    m.start();
    send(8'h00, 1'h0);
    send(8'h04, 1'h0);
    m.stop();
    chk(16'(regs.cfg), 16'h0082);
    m.start();
    send(8'h00, 1'h0);
    send(8'h05, 1'h1);
    m.stop();
    m.start();
    send(8'h00, 1'h0);
    send(8'h06, 1'h0);
    m.stop();
    chk(16'(regs.cfg), 16'h0000);
    chk(regs.thigh, 16'h0000);
    chk(16'(temp_value), 16'h0000);
    rd(w);
    chk(w, 16'h0000);
    chk(16'(tr_seen), 16'h0004);
    m.start();
    send(8'h19, 1'h1);
    m.stop();
    print_verdict();
  end
endmodule
